// ---- rtl/wdrst_core.v ----
// Purpose: watchdog timer and reset-source combiner with Wishbone registers
// Assumes: one 50 MHz clock; analog detector outputs and the reset pin
//   arrive asynchronously and are synchronised here
// Notes: the watchdog oscillator is a clock-enable derived from core_clk
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`include "wdrst_map.vh"
`default_nettype none

module wdrst_core #(
  parameter WD_BASE_TICKS = `WDRST_WD_BASE_TICKS,
  parameter EXT_MIN_NS = `WDRST_EXT_MIN_NS
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // reset sources, asynchronous
  input wire ext_rst_pin_n,
  input wire por_low,
  input wire brownout_low,
  // static fuses
  input wire ext_rst_en,
  input wire brownout_en,
  input wire always_on_fuse,
  input wire [19:0] startup_timeout,
  // processor core
  input wire dog_restart,
  input wire dog_irq_ack,
  input wire adc_en,
  output wire core_rst_n,
  output wire dog_irq,
  output reg ref_en,
  output wire comparator_bandgap_select
);

  // ========================================================================
  // derived constants
  localparam integer OSC_DIV_INT = `WDRST_CLK_HZ / `WDRST_OSC_HZ;
  localparam [8:0] OSC_DIV = OSC_DIV_INT[8:0];
  localparam integer EXT_CYC_RAW = (EXT_MIN_NS * `WDRST_CLK_MHZ + 999) / 1000;
  localparam integer EXT_CYC_INT = (EXT_CYC_RAW < 1) ? 1 : EXT_CYC_RAW;
  localparam [7:0] EXT_MIN_CYC = EXT_CYC_INT[7:0];
  localparam integer CE_INT = `WDRST_CE_CYCLES;
  localparam [1:0] CE_LAST = CE_INT[1:0] - 2'd1;
  localparam [2:0] SYNC_INIT = 3'b011;

  // time-out in oscillator ticks; reserved codes behave as the longest
  function [20:0] dog_limit;
    input [3:0] code;
    reg [31:0] base;
    reg [3:0] c;
    begin
      base = WD_BASE_TICKS;
      c = (code > `WDRST_WD_MAX_CODE) ? `WDRST_WD_MAX_CODE : code;
      dog_limit = base[20:0] << c;
    end
  endfunction

  // ========================================================================
  // input synchronisers
  reg [2:0] sync1_ff;
  reg [2:0] sync2_ff;
  wire [2:0] async_in;
  assign async_in = {brownout_low, por_low, ext_rst_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge core_clk) begin
        if (!rst_n) begin
          sync1_ff[gi] <= SYNC_INIT[gi];
          sync2_ff[gi] <= SYNC_INIT[gi];
        end else begin
          sync1_ff[gi] <= async_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire pin_n_s;
  wire por_s;
  wire brn_s;
  assign pin_n_s = sync2_ff[0];
  assign por_s = sync2_ff[1];
  assign brn_s = sync2_ff[2] & brownout_en;

  // ========================================================================
  // external pin qualification
  // a clockless reset cannot be seen here; the pin must stay low long
  // enough for the clocked filter, which also rejects short glitches
  reg [7:0] ext_cnt_ff;
  reg ext_act_ff;

  always @(posedge core_clk) begin
    if (!rst_n || !ext_rst_en || pin_n_s) begin
      ext_cnt_ff <= 8'h00;
      ext_act_ff <= 1'b0;
    end else if (ext_cnt_ff == EXT_MIN_CYC - 8'h01) begin
      ext_act_ff <= 1'b1;
    end else begin
      ext_cnt_ff <= ext_cnt_ff + 8'h01;
    end
  end

  // ========================================================================
  // reset combiner and start-up delay
  reg dog_pulse_ff;
  wire hold;
  // por and brown-out act on the synchronised level with no filter
  assign hold = por_s | ext_act_ff | brn_s | dog_pulse_ff;

  // every cause is stretched by the same fuse-set delay
  wdrst_dly u_dly (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hold(hold),
    .len(startup_timeout),
    .done(core_rst_n)
  );

  // ========================================================================
  // watchdog oscillator tick
  reg [8:0] div_ff;
  reg osc_tick_ff;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      div_ff <= 9'h000;
      osc_tick_ff <= 1'b0;
    end else if (div_ff == OSC_DIV - 9'h001) begin
      div_ff <= 9'h000;
      osc_tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 9'h001;
      osc_tick_ff <= 1'b0;
    end
  end

  // ========================================================================
  // wishbone slave
  wire req;
  wire wr;
  wire [7:0] d;
  wire hit_dog;
  wire hit_cause;
  wire hit_ref;
  reg [31:0] nxt_rdata;

  assign req = wb_cyc_i & wb_stb_i;
  // writes land at the edge where ack is high, one per request
  assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign d = wb_dat_i[7:0];
  assign hit_dog = (wb_adr_i == `WDRST_ADR_DOG);
  assign hit_cause = (wb_adr_i == `WDRST_ADR_CAUSE);
  assign hit_ref = (wb_adr_i == `WDRST_ADR_REF);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

  // ========================================================================
  // watchdog control and counter
  reg flag_ff;
  reg ie_ff;
  reg wde_ff;
  reg ce_ff;
  reg [1:0] ce_cnt_ff;
  reg [3:0] psel_ff;
  reg [20:0] wd_cnt_ff;
  reg dog_reset_flag_ff;
  reg brnf_ff;
  reg extf_ff;
  reg porf_ff;
  reg bg_sel_ff;

  wire wde_eff;
  wire ie_eff;
  wire wd_run;
  wire expire;
  wire dog_fire;
  wire irq_set;
  wire wr_dog;
  wire unlock;
  wire in_window;

  assign wde_eff = wde_ff | dog_reset_flag_ff | always_on_fuse;
  assign ie_eff = ie_ff & ~always_on_fuse;
  assign wd_run = wde_eff | ie_eff;
  assign expire = wd_run & osc_tick_ff &
                  (wd_cnt_ff == dog_limit(psel_ff) - 21'h000001);
  // combined mode: reset only once the earlier interrupt went unserviced
  assign dog_fire = expire & wde_eff & (~ie_eff | flag_ff);
  assign irq_set = expire & ie_eff & ~dog_fire;
  assign dog_irq = flag_ff & ie_eff;
  assign wr_dog = wr & hit_dog;
  assign unlock = wr_dog & d[`WDRST_DOG_CHG_BIT] & d[`WDRST_DOG_RSTEN_BIT];
  assign in_window = wr_dog & ce_ff & ~d[`WDRST_DOG_CHG_BIT];

  always @(posedge core_clk) begin
    if (!rst_n || !core_rst_n) begin
      flag_ff <= 1'b0;
      ie_ff <= 1'b0;
      wde_ff <= 1'b0;
      ce_ff <= 1'b0;
      ce_cnt_ff <= 2'd0;
      psel_ff <= 4'h0;
      wd_cnt_ff <= 21'h000000;
    end else begin
      if (unlock) begin
        ce_ff <= 1'b1;
        ce_cnt_ff <= CE_LAST;
      end else if (in_window) begin
        ce_ff <= 1'b0;
      end else if (ce_ff) begin
        if (ce_cnt_ff == 2'd0) begin
          ce_ff <= 1'b0;
        end else begin
          ce_cnt_ff <= ce_cnt_ff - 2'd1;
        end
      end
      // outside the window reset enable can only be set
      if (in_window) begin
        wde_ff <= d[`WDRST_DOG_RSTEN_BIT];
        psel_ff <= {d[`WDRST_DOG_PS3_BIT], d[`WDRST_DOG_PSLO_MSB:0]};
      end else if (wr_dog) begin
        wde_ff <= wde_ff | d[`WDRST_DOG_RSTEN_BIT];
      end
      if (wr_dog) begin
        ie_ff <= d[`WDRST_DOG_IRQEN_BIT];
      end else if (dog_irq_ack && wde_eff) begin
        ie_ff <= 1'b0;
      end
      // a new expiry beats a clear in the same cycle
      if (irq_set) begin
        flag_ff <= 1'b1;
      end else if (dog_irq_ack || (wr_dog && d[`WDRST_DOG_FLAG_BIT])) begin
        flag_ff <= 1'b0;
      end
      if (dog_restart || !wd_run || expire) begin
        wd_cnt_ff <= 21'h000000;
      end else if (osc_tick_ff) begin
        wd_cnt_ff <= wd_cnt_ff + 21'h000001;
      end
    end
  end

  // the pulse clears itself because expire restarts the counter and the oscillator tick lasts one cycle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      dog_pulse_ff <= 1'b0;
    end else begin
      dog_pulse_ff <= dog_fire;
    end
  end

  // ========================================================================
  // reset cause flags, kept across all but a power-on reset
  wire wr_cause;
  assign wr_cause = wr & hit_cause;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      {dog_reset_flag_ff, brnf_ff, extf_ff, porf_ff} <= `WDRST_CAUSE_RST;
    end else if (por_s) begin
      {dog_reset_flag_ff, brnf_ff, extf_ff, porf_ff} <= `WDRST_CAUSE_RST;
    end else begin
      if (dog_pulse_ff) begin
        dog_reset_flag_ff <= 1'b1;
      end else if (wr_cause && !d[`WDRST_CAUSE_DOG_BIT]) begin
        dog_reset_flag_ff <= 1'b0;
      end
      if (brn_s) begin
        brnf_ff <= 1'b1;
      end else if (wr_cause && !d[`WDRST_CAUSE_BRN_BIT]) begin
        brnf_ff <= 1'b0;
      end
      if (ext_act_ff) begin
        extf_ff <= 1'b1;
      end else if (wr_cause && !d[`WDRST_CAUSE_EXT_BIT]) begin
        extf_ff <= 1'b0;
      end
      if (wr_cause && !d[`WDRST_CAUSE_POR_BIT]) begin
        porf_ff <= 1'b0;
      end
    end
  end

  // ========================================================================
  // internal reference enable
  assign comparator_bandgap_select = bg_sel_ff;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      bg_sel_ff <= 1'b0;
      ref_en <= 1'b0;
    end else begin
      if (wr && hit_ref) begin
        bg_sel_ff <= d[`WDRST_REF_BG_BIT];
      end
      ref_en <= brownout_en | bg_sel_ff | adc_en;
    end
  end

  // ========================================================================
  // read data
  always @* begin
    nxt_rdata = 32'h00000000;
    if (hit_dog) begin
      nxt_rdata[7:0] = {flag_ff, ie_eff, psel_ff[3], ce_ff, wde_eff,
                        psel_ff[2:0]};
    end else if (hit_cause) begin
      nxt_rdata[3:0] = {dog_reset_flag_ff, brnf_ff, extf_ff, porf_ff};
    end else if (hit_ref) begin
      nxt_rdata[0] = bg_sel_ff;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/wdrst_map.vh ----
// Purpose: constants for the watchdog and reset-source block
// Assumes: 50 MHz core_clk, byte addresses on a classic Wishbone bus
// Notes: header only, definitions and nothing else
`ifndef WDRST_MAP_VH
`define WDRST_MAP_VH

// ==========================================================================
// clock and timing
`define WDRST_CLK_HZ 50000000
`define WDRST_CLK_MHZ 50
`define WDRST_OSC_HZ 128000
`define WDRST_WD_BASE_TICKS 2048
`define WDRST_WD_MAX_CODE 4'h9
`define WDRST_CE_CYCLES 4
`define WDRST_EXT_MIN_NS 2500

// ==========================================================================
// register byte addresses
`define WDRST_ADR_DOG 8'h00
`define WDRST_ADR_CAUSE 8'h04
`define WDRST_ADR_REF 8'h08

// ==========================================================================
// dog_control_reg fields
`define WDRST_DOG_FLAG_BIT 7
`define WDRST_DOG_IRQEN_BIT 6
`define WDRST_DOG_PS3_BIT 5
`define WDRST_DOG_CHG_BIT 4
`define WDRST_DOG_RSTEN_BIT 3
`define WDRST_DOG_PSLO_MSB 2

// ==========================================================================
// reset_cause_reg fields and reset values, and the reference register field
`define WDRST_CAUSE_DOG_BIT 3
`define WDRST_CAUSE_BRN_BIT 2
`define WDRST_CAUSE_EXT_BIT 1
`define WDRST_CAUSE_POR_BIT 0
`define WDRST_CAUSE_RST 4'h1
`define WDRST_REF_BG_BIT 0

`endif

// ---- rtl/wdrst_dly.v ----
// Purpose: start-up delay counter stretching the internal reset
// Assumes: hold is a level from logic on core_clk
// Notes: len is a static configuration value, sampled every cycle
`include "wdrst_map.vh"
`default_nettype none

// ==========================================================================
// delay counter
module wdrst_dly (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // control
  input wire hold,
  input wire [19:0] len,
  // result
  output reg done
);

  reg [19:0] cnt_ff;

  // any active source restarts the whole time-out, not just pauses it
  always @(posedge core_clk) begin
    if (!rst_n || hold) begin
      cnt_ff <= 20'h00000;
      done <= 1'b0;
    end else if (!done) begin
      if (cnt_ff >= len) begin
        done <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 20'h00001;
      end
    end
  end

endmodule

`default_nettype wire

// ---- sim/wdrst_chk.sv ----
// Purpose: port-level checks for wdrst_core
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound in from the bench top file
`default_nettype none
// ====
// checker
module wdrst_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sources and fuses
  input wire logic ext_rst_pin_n,
  input wire logic por_low,
  input wire logic brownout_low,
  input wire logic ext_rst_en,
  input wire logic brownout_en,
  input wire logic always_on_fuse,
  input wire logic [19:0] startup_timeout,
  // core side
  input wire logic dog_irq_ack,
  input wire logic adc_en,
  input wire logic core_rst_n,
  input wire logic dog_irq,
  input wire logic ref_en,
  input wire logic comparator_bandgap_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] lo_ff;
  // whole low time is counted, so this bounds the stretch from below only
  always_ff @(posedge core_clk) begin
    if (!rst_n || core_rst_n)
      lo_ff <= 21'h0;
    else
      lo_ff <= lo_ff + 21'h1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  AST_UNMAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 8'h00
    && wb_adr_i != 8'h04 && wb_adr_i != 8'h08 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_POR: assert property (
    por_low [*3] |-> ##[1:2] !core_rst_n)
    else $error("supply low did not reset");
  AST_BRN: assert property (
    (brownout_en && brownout_low) [*3] |-> ##[1:2] !core_rst_n)
    else $error("brown-out did not reset");
  AST_PIN: assert property (
    (ext_rst_en && !ext_rst_pin_n) [*8] |-> ##[1:3] !core_rst_n)
    else $error("pin low did not reset");
  AST_LEN: assert property (
    $rose(core_rst_n) |-> lo_ff >= {1'b0, startup_timeout})
    else $error("reset released too early");
  AST_REF: assert property (
    ref_en == $past(brownout_en || comparator_bandgap_select || adc_en))
    else $error("reference enable wrong");
  AST_FUSE: assert property (
    always_on_fuse |-> !dog_irq)
    else $error("interrupt with fuse set");
  AST_IACK: assert property (
    dog_irq && dog_irq_ack |=> !dog_irq)
    else $error("interrupt not cleared by service");
  AST_IHOLD: assert property (
    dog_irq && !dog_irq_ack && !wb_cyc_i |=> dog_irq || !core_rst_n)
    else $error("interrupt dropped unserviced");
endmodule
`default_nettype wire

// ---- sim/wdrst_sw.sv ----
// Purpose: model of core software restarting and serving the watchdog
// Assumes: restart and service are one-cycle pulses
// Notes: held still while the system reset is low
`default_nettype none
// ====
// software model
module wdrst_sw #(
  parameter int KICK = 300
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench control
  input wire logic kick_en,
  input wire logic [7:0] ack_dly,
  // core side
  input wire logic dog_irq,
  output logic dog_restart,
  output logic dog_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] kick_ff;
  logic [7:0] wait_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      kick_ff <= 9'h0;
      wait_ff <= 8'h0;
      dog_restart <= 1'b0;
      dog_irq_ack <= 1'b0;
    end else begin
      kick_ff <= (kick_ff == KICK) ? 9'h0 : kick_ff + 9'h1;
      // restart well inside the shortest time-out
      dog_restart <= kick_en && kick_ff == KICK;
      dog_irq_ack <= 1'b0;
      if (dog_irq && !dog_irq_ack) begin
        wait_ff <= wait_ff + 8'h1;
        if (wait_ff == ack_dly) begin
          dog_irq_ack <= 1'b1;
          wait_ff <= 8'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/wdrst_core_tb.sv ----
// Purpose: self-checking bench for wdrst_core
// Assumes: short base tick count and pin width for run time
// Notes: table rows cover registers, awkward cases follow
`default_nettype none
// ====
// bench
module wdrst_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] s;
    logic [7:0] d;
    logic adc;
    logic [7:0] e;
    logic [1:0] r;
  } wdrst_row_t;
  // r is the expected {bandgap select, reference enable} after the row
  wdrst_row_t rows [6] = '{'{8'h08, 4'hf, 8'h01, 1'b0, 8'h01, 2'h3},
    '{8'h08, 4'he, 8'h00, 1'b1, 8'h01, 2'h3},
    '{8'h08, 4'h1, 8'h00, 1'b0, 8'h00, 2'h0},
    '{8'h0c, 4'hf, 8'hff, 1'b1, 8'h00, 2'h1},
    '{8'h04, 4'hf, 8'h0f, 1'b0, 8'h01, 2'h0},
    '{8'h04, 4'hf, 8'h00, 1'b0, 8'h00, 2'h0}};
  logic core_clk, rst_n, cyc, we, pin_n, por, brn;
  logic ext_en, brn_en, fuse, adc_en, kick_en;
  logic [7:0] adr, ack_dly;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  wire [31:0] dat_o;
  wire ack, crst_n, irq, ref_en, bg, restart, iack;
  int fail_count, check_count, k;
  wdrst_core #(.WD_BASE_TICKS(4), .EXT_MIN_NS(100)) u_wdrst_core (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_rst_pin_n(pin_n),
    .por_low(por), .brownout_low(brn), .ext_rst_en(ext_en),
    .brownout_en(brn_en), .always_on_fuse(fuse),
    .startup_timeout(20'h00010), .dog_restart(restart),
    .dog_irq_ack(iack), .adc_en(adc_en), .core_rst_n(crst_n),
    .dog_irq(irq), .ref_en(ref_en), .comparator_bandgap_select(bg));
  // software halts with the system reset
  wdrst_sw u_wdrst_sw (.core_clk(core_clk), .rst_n(crst_n),
    .kick_en(kick_en), .ack_dly(ack_dly), .dog_irq(irq),
    .dog_restart(restart), .dog_irq_ack(iack));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task close_out;
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, ack, 1'b1);
      close_out;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  // waits on the interrupt (s=1) or the system reset (s=0)
  task wt(input logic s, input logic v, input int n);
    k = 0;
    while (((s ? irq : crst_n) !== v) && k < n) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  // a wait that must end in time; running out ends the run as a failure
  task need(input logic s, input logic v, input int n);
    wt(s, v, n);
    chk(k < n, 1'b1);
    if (k >= n)
      close_out;
  endtask
  task calm;
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
  endtask
  initial begin
    {rst_n, cyc, we, ext_en, brn_en, fuse, adc_en, kick_en, brn} = '0;
    {pin_n, por} = 2'b11;
    {adr, dat} = '0;
    sel = 4'hf;
    ack_dly = 8'h02;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    chk(crst_n, 1'b0);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    por <= 1'b0;
    need(0, 1, 40);
    rd(8'h04, 8'h01);
    foreach (rows[i]) begin
      sel <= rows[i].s;
      adc_en <= rows[i].adc;
      wr(rows[i].a, rows[i].d);
      sel <= 4'hf;
      rd(rows[i].a, rows[i].e);
      chk({bg, ref_en}, rows[i].r);
    end
    kick_en <= 1'b1;
    wr(8'h00, 8'h08);
    wt(0, 0, 4000);
    chk(k, 4000);
    kick_en <= 1'b0;
    wt(0, 0, 2000);
    chk(k > 800 && k < 1960, 1'b1);
    need(0, 1, 60);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    rd(8'h04, 8'h08);
    calm;
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h18);
    repeat (6) @(posedge core_clk);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h27);
    rd(8'h00, 8'h27);
    calm;
    wr(8'h00, 8'h40);
    wt(1, 1, 2000);
    chk(k < 2000, 1'b1);
    need(1, 0, 20);
    rd(8'h00, 8'h40);
    ack_dly <= 8'h28;
    wr(8'h00, 8'h48);
    need(1, 1, 2000);
    need(1, 0, 60);
    rd(8'h00, 8'h08);
    wt(0, 0, 2000);
    chk(k < 2000, 1'b1);
    need(0, 1, 60);
    calm;
    ext_en <= 1'b1;
    pin_n <= 1'b0;
    wt(0, 0, 20);
    chk(k < 20, 1'b1);
    pin_n <= 1'b1;
    need(0, 1, 40);
    rd(8'h04, 8'h02);
    ext_en <= 1'b0;
    pin_n <= 1'b0;
    wt(0, 0, 30);
    chk(k, 30);
    pin_n <= 1'b1;
    brn_en <= 1'b1;
    brn <= 1'b1;
    wt(0, 0, 20);
    chk(k < 20, 1'b1);
    brn <= 1'b0;
    need(0, 1, 40);
    rd(8'h04, 8'h06);
    fuse <= 1'b1;
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h08);
    fuse <= 1'b0;
    por <= 1'b1;
    wt(0, 0, 10);
    chk(k < 10, 1'b1);
    por <= 1'b0;
    need(0, 1, 40);
    rd(8'h04, 8'h01);
    close_out;
  end
endmodule
bind wdrst_core wdrst_chk u_wdrst_chk (.core_clk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ext_rst_pin_n,
  .por_low, .brownout_low, .ext_rst_en, .brownout_en, .always_on_fuse,
  .startup_timeout, .dog_irq_ack, .adc_en, .core_rst_n, .dog_irq,
  .ref_en, .comparator_bandgap_select);
`default_nettype wire
